/* File: core/atms_dev.sv */
// Register access over AHB-Lite and the register offsets are this design's own decisions.
`timescale 1ns/10ps
module atms_dev
  import atms_pkg::*;
(
  input wire logic I_CLK_SYS,
  input wire logic I_RST,
  atms_link_if.dev LINK,
  input wire logic [RES_W-1:0] I_SAMPLE_DATA,
  output logic [CH_W-1:0] O_SAMPLE_CH,
  output logic O_SAMPLE_HOLD
);

  function automatic logic [CH_W-1:0] seq_ch(input logic [1:0] sel, input logic [2:0] idx);
    unique case (sel)
      SEQ_ASCEND: seq_ch = idx;
      SEQ_EVEN: seq_ch = {idx[1:0], 1'b0};
      SEQ_EVEN_PAIRS: seq_ch = {idx[2:1], 1'b0};
      SEQ_ZERO_TWO: seq_ch = {1'b0, idx[0], 1'b0};
    endcase
  endfunction

  function automatic logic [FIFO_CW-1:0] thr_lvl(input logic [1:0] sel);
    unique case (sel)
      THR_FULL: thr_lvl = LVL_FULL;
      THR_3Q: thr_lvl = LVL_3Q;
      THR_HALF: thr_lvl = LVL_HALF;
      default: thr_lvl = LVL_1Q;
    endcase
  endfunction

  logic [4:0] pins;
  logic [4:0] s1_q;
  logic [4:0] s2_q;
  logic [4:0] s3_q;
  logic sclk_rise;
  logic cs_low;
  logic frame_start;
  logic stb_fall;
  logic stb_rise;
  logic sdi_bit;

  assign pins = {LINK.sclk, LINK.cs_n, LINK.fs, LINK.sdi, LINK.strobe_n};

  // two-stage synchronisers, third stage for edges
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      s1_q <= LINK_IDLE;
      s2_q <= LINK_IDLE;
      s3_q <= LINK_IDLE;
    end else begin
      s1_q <= pins;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  assign sclk_rise = s2_q[P_SCLK] & ~s3_q[P_SCLK];
  assign cs_low = ~s2_q[P_CS];
  assign frame_start = (cs_low & s3_q[P_CS]) | (cs_low & s2_q[P_FS] & ~s3_q[P_FS]);
  assign stb_fall = ~s2_q[P_STB] & s3_q[P_STB] & ~cs_low;
  assign stb_rise = s2_q[P_STB] & ~s3_q[P_STB] & ~cs_low;
  assign sdi_bit = s2_q[P_SDI];

  logic [CFG_W-1:0] cfg_q;
  logic [1:0] mode;
  logic sweep;
  logic in_frame_q;
  logic [CNT_W-1:0] cnt_q;
  logic [WORD_W-1:0] rx_q;
  logic [WORD_W-1:0] sh_q;
  logic oe_q;
  logic edge_ok;
  logic nib_done;
  logic word_done;
  logic conv_edge;
  logic [3:0] nib;
  logic [WORD_W-1:0] word;
  logic [3:0] cmd;

  assign mode = cfg_q[CFG_MODE_MSB:CFG_MODE_LSB];
  assign sweep = mode[1];
  assign edge_ok = in_frame_q & cs_low & sclk_rise;
  assign nib = {rx_q[2:0], sdi_bit};
  assign word = {rx_q[WORD_W-2:0], sdi_bit};
  assign cmd = word[WORD_W-1:WORD_W-4];
  assign nib_done = edge_ok & (cnt_q == NIB_LAST);
  assign word_done = edge_ok & (cnt_q == SHORT_LAST);
  assign conv_edge = edge_ok & (cnt_q == (cfg_q[CFG_LONG_BIT] ? LONG_LAST : SHORT_LAST));

  atms_state_t st_q;
  logic ext_q;
  logic [TMR_W-1:0] tmr_q;
  logic conv_done;
  logic halt_q;
  logic pend_q;
  logic int_q;
  logic frame_trig;
  logic [CH_W-1:0] sel_ch_q;
  logic [2:0] idx_q;
  logic [CH_W-1:0] conv_ch;
  logic [RES_W-1:0] hold_q;

  logic [RES_W-1:0] mem [FIFO_DEPTH];
  logic [FIFO_AW-1:0] wr_q;
  logic [FIFO_AW-1:0] rd_q;
  logic [FIFO_CW-1:0] fcnt_q;
  logic push;
  logic pop;
  logic thr_now;
  logic fifo_clr;
  logic cfg_wr;
  logic [RES_W-1:0] out_word;

  assign conv_done = (st_q == ST_CONVERT) & (tmr_q == '0);
  assign cfg_wr = word_done & (cmd == CMD_WRITE_CFG);
  // frame triggers: a select, or any plain frame in fifo modes
  assign frame_trig = ~nib[CMD_SEL_BIT] | ((mode != MODE_ONE_SHOT)
                      & (nib != CMD_WRITE_CFG) & (nib != CMD_READ_FIFO));
  assign conv_ch = sweep ? seq_ch(cfg_q[CFG_SEQ_MSB:CFG_SEQ_LSB], idx_q) : sel_ch_q;
  assign push = conv_done & (mode != MODE_ONE_SHOT) & (fcnt_q != LVL_FULL);
  assign pop = word_done & (cmd == CMD_READ_FIFO) & (fcnt_q != '0) & (mode != MODE_ONE_SHOT);
  assign thr_now = push & ((fcnt_q + 4'h1) == thr_lvl(cfg_q[CFG_THR_MSB:CFG_THR_LSB]));
  assign fifo_clr = cfg_wr | (word_done & pend_q & (cmd != CMD_READ_FIFO))
                    | (stb_fall & pend_q & (mode == MODE_REP_SWEEP));
  assign out_word = (mode == MODE_ONE_SHOT) ? hold_q : mem[rd_q];

  // serial frame: count edges, shift command in and result out
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      in_frame_q <= 1'b0;
      cnt_q <= '0;
      rx_q <= '0;
      sh_q <= '0;
      oe_q <= 1'b0;
    end else begin
      oe_q <= cs_low;
      if (frame_start) begin
        in_frame_q <= 1'b1;
        cnt_q <= '0;
        sh_q <= {out_word, {(WORD_W-RES_W){1'b0}}};
      end else if (!cs_low) begin
        in_frame_q <= 1'b0;
      end else if (edge_ok) begin
        if (cnt_q != LONG_LAST) begin
          cnt_q <= cnt_q + 5'h01;
        end
        rx_q <= word;
        sh_q <= {sh_q[WORD_W-2:0], 1'b0};
      end
    end
  end

  // configuration and channel select
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      cfg_q <= CFG_RESET;
      sel_ch_q <= '0;
    end else begin
      if (cfg_wr) begin
        cfg_q <= word[CFG_W-1:0];
      end
      if (nib_done && !nib[CMD_SEL_BIT]) begin
        sel_ch_q <= nib[CH_W-1:0];
      end
    end
  end

  // sample and convert sequencing
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      st_q <= ST_IDLE;
      ext_q <= 1'b0;
      tmr_q <= '0;
    end else begin
      unique case (st_q)
        ST_IDLE: begin
          if (stb_fall && !halt_q) begin
            st_q <= ST_SAMPLE;
            ext_q <= 1'b1;
          end else if (nib_done && frame_trig && !halt_q) begin
            st_q <= ST_SAMPLE;
            ext_q <= 1'b0;
          end
        end
        ST_SAMPLE: begin
          if (ext_q ? stb_rise : conv_edge) begin
            st_q <= ST_CONVERT;
            tmr_q <= TMR_W'(CONV_CYC - 1);
          end
        end
        ST_CONVERT: begin
          if (tmr_q == '0) begin
            st_q <= ST_IDLE;
          end else begin
            tmr_q <= tmr_q - 9'h001;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // sweep position, halt, pending threshold, interrupt
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      idx_q <= '0;
      halt_q <= 1'b0;
      pend_q <= 1'b0;
      int_q <= 1'b0;
    end else begin
      if (cfg_wr) begin
        idx_q <= '0;
      end else if (conv_done && sweep) begin
        idx_q <= idx_q + 3'h1;
      end
      if (mode == MODE_SWEEP && push && (thr_now || idx_q == 3'h7)) begin
        halt_q <= 1'b1;
      end else if (cfg_wr || (pop && fcnt_q == 4'h1)) begin
        halt_q <= 1'b0;
      end
      if (thr_now && (mode == MODE_REPEAT || mode == MODE_REP_SWEEP)) begin
        pend_q <= 1'b1;
      end else if (word_done || fifo_clr) begin
        pend_q <= 1'b0;
      end
      if ((conv_done && mode == MODE_ONE_SHOT) || thr_now) begin
        int_q <= 1'b1;
      end else if (frame_start) begin
        int_q <= 1'b0;
      end
    end
  end

  // fifo pointers and one-shot holding register
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      wr_q <= '0;
      rd_q <= '0;
      fcnt_q <= '0;
      hold_q <= '0;
    end else begin
      if (conv_done && mode == MODE_ONE_SHOT) begin
        hold_q <= I_SAMPLE_DATA;
      end
      if (push) begin
        wr_q <= wr_q + 3'h1;
      end
      if (fifo_clr) begin
        rd_q <= wr_q;
        fcnt_q <= push ? 4'h1 : 4'h0;
      end else begin
        if (pop) begin
          rd_q <= rd_q + 3'h1;
        end
        fcnt_q <= fcnt_q + (push ? 4'h1 : 4'h0) - (pop ? 4'h1 : 4'h0);
      end
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (push) begin
      mem[wr_q] <= I_SAMPLE_DATA;
    end
  end

  // pin and user-side outputs
  logic pin_q;

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      pin_q <= 1'b1;
      O_SAMPLE_CH <= '0;
      O_SAMPLE_HOLD <= 1'b0;
    end else begin
      pin_q <= cfg_q[CFG_EOC_BIT] ? (st_q != ST_CONVERT) : ~int_q;
      O_SAMPLE_CH <= conv_ch;
      O_SAMPLE_HOLD <= (st_q == ST_SAMPLE);
    end
  end

  assign LINK.serial_result_out = sh_q[WORD_W-1];
  assign LINK.sdo_oe = oe_q;
  assign LINK.status_pin = pin_q;

endmodule

/* File: core/atms_pkg.sv */
package atms_pkg;
  // converter result and channel widths
  localparam int RES_W = 10;
  localparam int CH_W = 3;
  localparam int WORD_W = 16;
  localparam int CFG_W = 12;
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_AW = 3;
  localparam int FIFO_CW = 4;
  localparam int CNT_W = 5;

  // conversion modes
  localparam logic [1:0] MODE_ONE_SHOT = 2'h0;
  localparam logic [1:0] MODE_REPEAT = 2'h1;
  localparam logic [1:0] MODE_SWEEP = 2'h2;
  localparam logic [1:0] MODE_REP_SWEEP = 2'h3;

  // config word fields
  localparam int CFG_LONG_BIT = 9;
  localparam int CFG_MODE_MSB = 6;
  localparam int CFG_MODE_LSB = 5;
  localparam int CFG_SEQ_MSB = 4;
  localparam int CFG_SEQ_LSB = 3;
  localparam int CFG_EOC_BIT = 2;
  localparam int CFG_THR_MSB = 1;
  localparam int CFG_THR_LSB = 0;
  localparam logic [CFG_W-1:0] CFG_RESET = 12'h000;

  // sweep orders and fifo thresholds
  localparam logic [1:0] SEQ_ASCEND = 2'h0;
  localparam logic [1:0] SEQ_EVEN = 2'h1;
  localparam logic [1:0] SEQ_EVEN_PAIRS = 2'h2;
  localparam logic [1:0] SEQ_ZERO_TWO = 2'h3;
  localparam logic [1:0] THR_FULL = 2'h0;
  localparam logic [1:0] THR_3Q = 2'h1;
  localparam logic [1:0] THR_HALF = 2'h2;
  localparam logic [FIFO_CW-1:0] LVL_FULL = 4'h8;
  localparam logic [FIFO_CW-1:0] LVL_3Q = 4'h6;
  localparam logic [FIFO_CW-1:0] LVL_HALF = 4'h4;
  localparam logic [FIFO_CW-1:0] LVL_1Q = 4'h2;

  // serial commands, top nibble of the word
  localparam logic [3:0] CMD_WRITE_CFG = 4'hA;
  localparam logic [3:0] CMD_READ_FIFO = 4'hE;
  localparam int CMD_SEL_BIT = 3;

  // frame edge counts
  localparam int NIB_EDGE = 4;
  localparam int SHORT_CONV_EDGE = 16;
  localparam int LONG_CONV_EDGE = 28;
  localparam logic [CNT_W-1:0] NIB_LAST = 5'(NIB_EDGE - 1);
  localparam logic [CNT_W-1:0] SHORT_LAST = 5'(SHORT_CONV_EDGE - 1);
  localparam logic [CNT_W-1:0] LONG_LAST = 5'(LONG_CONV_EDGE - 1);

  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int CONV_TIME_NS = 1400;
  localparam int CONV_CYC = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_LOW_NS = 800;
  localparam int STROBE_LOW_CYC = (STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SCLK_HALF_CYC = 8;
  localparam int HOST_GAP_CYC = 2 * CONV_CYC;
  localparam int TMR_W = 9;

  // synchroniser lanes on the device side
  localparam int P_SCLK = 4;
  localparam int P_CS = 3;
  localparam int P_FS = 2;
  localparam int P_SDI = 1;
  localparam int P_STB = 0;
  localparam logic [4:0] LINK_IDLE = 5'h09;

  // controller registers
  localparam logic [7:0] HREG_CMD = 8'h00;
  localparam logic [7:0] HREG_STAT = 8'h04;
  localparam logic [7:0] HREG_RESP = 8'h08;
  localparam logic [7:0] HREG_STRB = 8'h0C;
  localparam int HCMD_LONG_BIT = 16;
  localparam int HCMD_FS_BIT = 17;

  typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT} atms_state_t;
  typedef enum logic [2:0] {H_IDLE, H_FSYNC, H_FRAME, H_STROBE, H_GAP} atms_hstate_t;
endpackage

/* File: core/atms_link_if.sv */
`timescale 1ns/10ps
interface atms_link_if;
  logic sclk;
  logic cs_n;
  logic fs;
  logic sdi;
  logic strobe_n;
  logic serial_result_out;
  logic sdo_oe;
  logic sdo_line;
  logic status_pin;

  assign sdo_line = sdo_oe ? serial_result_out : 1'b0;

  modport dev (
    input sclk, cs_n, fs, sdi, strobe_n,
    output serial_result_out, sdo_oe, status_pin
  );
  modport host (
    output sclk, cs_n, fs, sdi, strobe_n,
    input sdo_line, status_pin
  );
endinterface

/* File: core/atms_host.sv */
`timescale 1ns/10ps
module atms_host
  import atms_pkg::*;
(
  input wire logic I_CLK_SYS,
  input wire logic I_RST,
  atms_link_if.host LINK,
  input wire logic I_HSEL,
  input wire logic [31:0] I_HADDR,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic [2:0] I_HSIZE,
  input wire logic [31:0] I_HWDATA,
  input wire logic I_HREADY,
  output logic [31:0] O_HRDATA,
  output logic O_HREADYOUT,
  output logic O_HRESP
);

  logic ap_q;
  logic [7:0] aa_q;
  logic wr_cmd;
  logic wr_strb;
  logic [1:0] in1_q;
  logic [1:0] in2_q;
  atms_hstate_t st_q;
  logic [WORD_W-1:0] cmd_q;
  logic [WORD_W-1:0] tx_q;
  logic [WORD_W-1:0] rx_q;
  logic [WORD_W-1:0] resp_q;
  logic long_q;
  logic fs_mode_q;
  logic [TMR_W-1:0] hc_q;
  logic [CNT_W-1:0] bn_q;
  logic sclk_q;
  logic cs_n_q;
  logic fs_q;
  logic stb_n_q;
  logic busy;

  assign busy = (st_q != H_IDLE);
  assign wr_cmd = ap_q & (aa_q == HREG_CMD) & ~busy;
  assign wr_strb = ap_q & (aa_q == HREG_STRB) & ~busy;

  // bus slave: zero wait, write data taken in data phase
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      ap_q <= 1'b0;
      aa_q <= '0;
      O_HRDATA <= 32'h0000_0000;
      O_HREADYOUT <= 1'b1;
      O_HRESP <= 1'b0;
    end else begin
      ap_q <= I_HSEL & I_HTRANS[1] & I_HREADY & I_HWRITE;
      aa_q <= I_HADDR[7:0];
      if (I_HSEL && I_HTRANS[1] && I_HREADY && !I_HWRITE) begin
        unique case (I_HADDR[7:0])
          HREG_CMD: O_HRDATA <= {14'h0000, fs_mode_q, long_q, cmd_q};
          HREG_STAT: O_HRDATA <= {30'h0000_0000, in2_q[1], busy};
          HREG_RESP: O_HRDATA <= {16'h0000, resp_q};
          default: O_HRDATA <= 32'h0000_0000;
        endcase
      end
    end
  end

  // sdo and status pin synchronisers
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      in1_q <= 2'h2;
      in2_q <= 2'h2;
    end else begin
      in1_q <= {LINK.status_pin, LINK.sdo_line};
      in2_q <= in1_q;
    end
  end

  // frame, frame sync and strobe generation
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      st_q <= H_IDLE;
      cmd_q <= '0;
      tx_q <= '0;
      rx_q <= '0;
      resp_q <= '0;
      long_q <= 1'b0;
      fs_mode_q <= 1'b0;
      hc_q <= '0;
      bn_q <= '0;
      sclk_q <= 1'b0;
      cs_n_q <= 1'b1;
      fs_q <= 1'b0;
      stb_n_q <= 1'b1;
    end else begin
      unique case (st_q)
        H_IDLE: begin
          hc_q <= TMR_W'(SCLK_HALF_CYC - 1);
          bn_q <= '0;
          if (wr_cmd) begin
            cmd_q <= I_HWDATA[WORD_W-1:0];
            tx_q <= I_HWDATA[WORD_W-1:0];
            long_q <= I_HWDATA[HCMD_LONG_BIT];
            fs_mode_q <= I_HWDATA[HCMD_FS_BIT];
            cs_n_q <= 1'b0;
            fs_q <= I_HWDATA[HCMD_FS_BIT];
            st_q <= I_HWDATA[HCMD_FS_BIT] ? H_FSYNC : H_FRAME;
          end else if (wr_strb) begin
            cs_n_q <= 1'b1;
            stb_n_q <= 1'b0;
            hc_q <= TMR_W'(STROBE_LOW_CYC - 1);
            st_q <= H_STROBE;
          end
        end
        H_FSYNC: begin
          if (hc_q == '0) begin
            fs_q <= 1'b0;
            hc_q <= TMR_W'(SCLK_HALF_CYC - 1);
            st_q <= H_FRAME;
          end else begin
            hc_q <= hc_q - 9'h001;
          end
        end
        H_FRAME: begin
          if (hc_q != '0) begin
            hc_q <= hc_q - 9'h001;
          end else begin
            hc_q <= TMR_W'(SCLK_HALF_CYC - 1);
            sclk_q <= ~sclk_q;
            if (!sclk_q) begin
              if (bn_q < 5'(WORD_W)) begin
                rx_q <= {rx_q[WORD_W-2:0], in2_q[0]};
              end
            end else begin
              tx_q <= {tx_q[WORD_W-2:0], 1'b0};
              bn_q <= bn_q + 5'h01;
              if (bn_q == (long_q ? LONG_LAST : SHORT_LAST)) begin
                resp_q <= rx_q;
                cs_n_q <= fs_mode_q ? 1'b0 : 1'b1;
                hc_q <= TMR_W'(HOST_GAP_CYC - 1);
                st_q <= H_GAP;
              end
            end
          end
        end
        H_STROBE: begin
          if (hc_q == '0) begin
            stb_n_q <= 1'b1;
            hc_q <= TMR_W'(HOST_GAP_CYC - 1);
            st_q <= H_GAP;
          end else begin
            hc_q <= hc_q - 9'h001;
          end
        end
        H_GAP: begin
          if (hc_q == '0) begin
            st_q <= H_IDLE;
          end else begin
            hc_q <= hc_q - 9'h001;
          end
        end
        default: st_q <= H_IDLE;
      endcase
    end
  end

  assign LINK.sclk = sclk_q;
  assign LINK.cs_n = cs_n_q;
  assign LINK.fs = fs_q;
  assign LINK.sdi = tx_q[WORD_W-1];
  assign LINK.strobe_n = stb_n_q;

endmodule

/* File: tb/atms_sva.sv */
`timescale 1ns/10ps
module atms_sva
  import atms_pkg::*;
(
  input wire logic I_CLK_SYS,
  input wire logic I_RST,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic fs,
  input wire logic strobe_n,
  input wire logic sdo_oe,
  input wire logic O_SAMPLE_HOLD
);
  default clocking cb @(posedge I_CLK_SYS);
  endclocking
  default disable iff (I_RST);
  logic sclk_q, cs_q, fs_q, stb_q, start;
  logic [CNT_W-1:0] rise_q;
  logic [TMR_W-1:0] low_q, gap_q;
  assign start = (cs_q && !cs_n) || (fs && !fs_q);
  // frame edge count, strobe ownership, strobe low time, frame gap
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      sclk_q <= 1'b0;
      cs_q <= 1'b1;
      fs_q <= 1'b0;
      stb_q <= 1'b0;
      rise_q <= '0;
      low_q <= '0;
      gap_q <= '1;
    end else begin
      sclk_q <= sclk;
      cs_q <= cs_n;
      fs_q <= fs;
      stb_q <= !strobe_n || (stb_q && !start);
      if (start) rise_q <= '0;
      else if (sclk && !sclk_q && rise_q != '1) rise_q <= rise_q + 1'b1;
      if (strobe_n) low_q <= '0;
      else if (low_q != '1) low_q <= low_q + 1'b1;
      if (cs_n && !cs_q) gap_q <= '0;
      else if (gap_q != '1) gap_q <= gap_q + 1'b1;
    end
  end
  sequence s_stb_fall;
    $fell(strobe_n) && cs_n;
  endsequence
  sequence s_hold_kept;
    ##[1:6] O_SAMPLE_HOLD ##1 O_SAMPLE_HOLD[*8];
  endsequence
  property p_stb_start;
    s_stb_fall |-> s_hold_kept;
  endproperty
  a_stb_start: assert property (p_stb_start)
    else $error("no sampling after strobe fall");
  property p_stb_end;
    $rose(strobe_n) && stb_q |-> ##[1:6] !O_SAMPLE_HOLD;
  endproperty
  a_stb_end: assert property (p_stb_end)
    else $error("sampling kept after strobe rise");
  property p_stb_masked;
    $fell(strobe_n) && !cs_n && !O_SAMPLE_HOLD |=> !O_SAMPLE_HOLD[*6];
  endproperty
  a_stb_masked: assert property (p_stb_masked)
    else $error("strobe acted while selected");
  property p_nib;
    $rose(O_SAMPLE_HOLD) && !stb_q |-> rise_q == NIB_EDGE;
  endproperty
  a_nib: assert property (p_nib)
    else $error("sampling start off the fourth edge");
  property p_conv_edge;
    $fell(O_SAMPLE_HOLD) && !stb_q |-> rise_q == SHORT_CONV_EDGE || rise_q == LONG_CONV_EDGE;
  endproperty
  a_conv_edge: assert property (p_conv_edge)
    else $error("conversion start at wrong edge");
  property p_low_time;
    $rose(strobe_n) |-> low_q >= STROBE_LOW_CYC;
  endproperty
  a_low_time: assert property (p_low_time)
    else $error("strobe low too short");
  property p_one_trig;
    !strobe_n |-> cs_n && !fs;
  endproperty
  a_one_trig: assert property (p_one_trig)
    else $error("triggers mixed");
  property p_gap;
    $fell(cs_n) |-> gap_q >= CONV_CYC;
  endproperty
  a_gap: assert property (p_gap)
    else $error("frames too close");
  property p_fs;
    $rose(fs) |-> !cs_n ##1 !sclk[*6];
  endproperty
  a_fs: assert property (p_fs)
    else $error("frame sync misplaced");
  property p_oe;
    cs_n[*6] |-> !sdo_oe;
  endproperty
  a_oe: assert property (p_oe)
    else $error("output driven while deselected");
endmodule

/* File: tb/tb_adc_trigger_mode_sequencer.sv */
`timescale 1ns/10ps
module tb_adc_trigger_mode_sequencer;
  import atms_pkg::*;
  typedef struct packed {
    logic [31:0] word;
    logic [2:0] ch;
  } atms_row_t;
  atms_row_t rows [4] = '{'{32'h0000_3000, 3'h3}, '{32'h0000_7000, 3'h7},
    '{32'h0000_0000, 3'h0}, '{32'h0002_5000, 3'h5}};
  logic clk, rst, hsel, hwrite, hrdy, hresp, hold, hold_q;
  logic [1:0] htrans;
  logic [2:0] hsize, ch;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [RES_W-1:0] sdata;
  logic [2:0] log_q [64];
  int bad_count, checked, nconv, hcnt, low_cnt;
  atms_link_if link ();
  atms_host i_atms_host (.I_CLK_SYS(clk), .I_RST(rst), .LINK(link), .I_HSEL(hsel),
    .I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(hsize),
    .I_HWDATA(hwdata), .I_HREADY(hrdy), .O_HRDATA(hrdata), .O_HREADYOUT(hrdy),
    .O_HRESP(hresp));
  atms_dev i_atms_dev (.I_CLK_SYS(clk), .I_RST(rst), .LINK(link), .I_SAMPLE_DATA(sdata),
    .O_SAMPLE_CH(ch), .O_SAMPLE_HOLD(hold));
  atms_sva i_atms_sva (.I_CLK_SYS(clk), .I_RST(rst), .sclk(link.sclk), .cs_n(link.cs_n),
    .fs(link.fs), .strobe_n(link.strobe_n), .sdo_oe(link.sdo_oe), .O_SAMPLE_HOLD(hold));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // analog source follows channel, conversion log
  always @(posedge clk) begin
    sdata <= {7'h55, ch};
    hold_q <= hold;
    if (rst) begin
      {low_cnt, hcnt, nconv} <= '0;
    end else begin
      if (!link.status_pin) low_cnt <= low_cnt + 1;
      if (hold && !hold_q) hcnt <= 1;
      else if (hold) hcnt <= hcnt + 1;
      if (!hold && hold_q) begin
        log_q[nconv[5:0]] <= ch;
        nconv <= nconv + 1;
      end
    end
  end
  function automatic logic [31:0] res(input logic [2:0] c);
    return {16'h0000, 7'h55, c, 6'h00};
  endfunction
  task automatic test_done;
    $display("checked %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  task automatic tick(inout int n);
    @(posedge clk);
    n++;
    if (n > 2000) begin
      bad_count++;
      test_done();
    end
  endtask
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h00_0000, a};
    hwrite <= wr;
    @(posedge clk);
    while (hrdy !== 1'b1) tick(n);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    while (hrdy !== 1'b1) tick(n);
    rd = hrdata;
  endtask
  task automatic run(input logic [31:0] w, input logic [7:0] a);
    int n;
    n = 0;
    ahb(1'b1, a, w);
    @(posedge clk);
    ahb(1'b0, HREG_STAT, 32'h0);
    while (rd[0] !== 1'b0) begin
      tick(n);
      ahb(1'b0, HREG_STAT, 32'h0);
    end
  endtask
  task automatic rd_fifo(input logic [2:0] c);
    run(32'h0000_E000, HREG_CMD);
    ahb(1'b0, HREG_RESP, 32'h0);
    chk(rd, res(c), "fifo result");
  endtask
  task automatic stat(input logic v);
    ahb(1'b0, HREG_STAT, 32'h0);
    chk(32'(rd[1]), 32'(v), "status pin");
  endtask
  initial begin
    int n0;
    {hsel, haddr, htrans, hwrite, hwdata} = '0;
    rst = 1'b1;
    hsize = 3'h2;
    {bad_count, checked} = '0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 4; i++) begin
      run(rows[i].word, HREG_CMD);
      chk(32'(log_q[nconv-1]), 32'(rows[i].ch), "channel");
      chk((hcnt + 8) / 16, 12, "short sampling");
      stat(1'b0);
      ahb(1'b0, HREG_RESP, 32'h0);
      if (i > 0) chk(rd, res(rows[i-1].ch), "previous result");
    end
    $display("test rows done");
    n0 = nconv;
    run(32'h0, HREG_STRB);
    chk(nconv - n0, 1, "strobe conversion");
    chk(32'(hcnt > STROBE_LOW_CYC - 5 && hcnt < STROBE_LOW_CYC + 5), 1, "window");
    rd_fifo(3'h5);
    $display("test strobe done");
    run(32'h0000_A004, HREG_CMD);
    n0 = low_cnt;
    run(32'h0000_2000, HREG_CMD);
    chk(low_cnt - n0, CONV_CYC, "eoc while converting");
    stat(1'b1);
    run(32'h0000_A200, HREG_CMD);
    run(32'h0001_4000, HREG_CMD);
    chk((hcnt + 8) / 16, 24, "long sampling");
    $display("test pin and long done");
    run(32'h0001_A042, HREG_CMD);
    n0 = nconv;
    repeat (4) run(32'h0000_C000, HREG_CMD);
    stat(1'b0);
    run(32'h0000_C000, HREG_CMD);
    chk(nconv - n0, 4, "sweep stop");
    for (int k = 0; k < 4; k++) chk(32'(log_q[n0+k]), k, "sweep order");
    for (int k = 0; k < 4; k++) rd_fifo(3'(k));
    n0 = nconv;
    run(32'h0000_C000, HREG_CMD);
    chk(nconv - n0, 1, "next sweep");
    $display("test sweep done");
    run(32'h0000_A063, HREG_CMD);
    n0 = nconv;
    repeat (2) run(32'h0000_C000, HREG_CMD);
    stat(1'b0);
    repeat (2) run(32'h0000_C000, HREG_CMD);
    chk(nconv - n0, 4, "sweep continues");
    rd_fifo(3'h2);
    rd_fifo(3'h3);
    run(32'h0000_A073, HREG_CMD);
    n0 = nconv;
    repeat (3) run(32'h0000_C000, HREG_CMD);
    for (int k = 0; k < 3; k++) chk(32'(log_q[n0+k]), 32'(k & 2), "pair order");
    run(32'h0000_A023, HREG_CMD);
    run(32'h0000_5000, HREG_CMD);
    run(32'h0000_C000, HREG_CMD);
    rd_fifo(3'h5);
    rd_fifo(3'h5);
    $display("test repeat done");
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk(32'({hrdy, hresp, link.cs_n, link.strobe_n, link.status_pin, hold}), 32'h2E, "idle");
    ahb(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h0, "unmapped read");
    $display("test reset done");
    test_done();
  end
endmodule
